//--- hdl/tec_pkg.sv
// Package: addresses, bit positions and reset values of the timer and external interrupt control
package tec_pkg;

  // ----------------------------------------------------------------------
  // Special function register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] TIMER_EXTINT_CONTROL_ADDR    = 8'h88;
  localparam logic [7:0] INTERRUPT_ENABLE_SECOND_ADDR = 8'hB1;

  // ----------------------------------------------------------------------
  // Bit positions in timer_extint_control
  // ----------------------------------------------------------------------
  localparam int unsigned TIMER_ONE_OVERFLOW_BIT  = 7;
  localparam int unsigned TIMER_ONE_RUN_BIT       = 6;
  localparam int unsigned TIMER_ZERO_OVERFLOW_BIT = 5;
  localparam int unsigned TIMER_ZERO_RUN_BIT      = 4;
  localparam int unsigned EXT_ONE_FLAG_BIT        = 3;
  localparam int unsigned EXT_ONE_TRIGGER_BIT     = 2;
  localparam int unsigned EXT_ZERO_FLAG_BIT       = 1;
  localparam int unsigned EXT_ZERO_TRIGGER_BIT    = 0;

  // ----------------------------------------------------------------------
  // Bit positions in interrupt_enable_second
  // ----------------------------------------------------------------------
  localparam int unsigned SMARTCARD_IRQ_ENABLE_BIT = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] TIMER_EXTINT_CONTROL_RESET = 8'h00;
  localparam logic       SMARTCARD_IRQ_ENABLE_RESET = 1'b0;
  localparam logic [7:0] READ_IDLE_VALUE            = 8'h00;

  // Trigger select encodings
  localparam logic TRIGGER_LOW_LEVEL    = 1'b0;
  localparam logic TRIGGER_FALLING_EDGE = 1'b1;

endpackage : tec_pkg

//--- hdl/tec_extint_if.sv
// Interface: trigger select and detection between control registers and pin detector
`timescale 1ns/1ns
interface tec_extint_if;
  logic trigger_select;
  logic detect;

  modport ctrl (output trigger_select, input detect);
  modport det  (input trigger_select, output detect);
endinterface : tec_extint_if

//--- hdl/tec_extint_detect.sv
// Module: external interrupt pin synchroniser with level and falling-edge detection
`timescale 1ns/1ns
module tec_extint_detect (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_pin_n,
  tec_extint_if.det port_if
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // --------------------------------------------------------------------
  // Two-stage synchroniser, then one stage of history
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= i_pin_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Low level or falling edge per trigger select
  always_comb begin
    if (port_if.trigger_select == tec_pkg::TRIGGER_FALLING_EDGE) begin
      port_if.detect = prev_q & ~sync2_q; // see RULE12
    end else begin
      port_if.detect = ~sync2_q; // see RULE12
    end
  end

endmodule : tec_extint_detect

//--- hdl/tec_control_regs.sv
// Module: timer run, overflow flag, external interrupt and smartcard enable registers
// --------------------------------------------------------------------------
// Overview of operation
// RULE1: second enable register keeps only smartcard enable at bit 3, reset low.
// RULE2: timer one overflow sets bit 7; vectoring to its handler clears it.
// RULE3: bit 6 starts timer one when one, stops it when zero.
// RULE4: timer zero overflow sets bit 5; vectoring to its handler clears it.
// RULE5: a detected condition on external pin zero sets bit 1.
// RULE6: edge mode clears bit 1 on servicing; level mode leaves it set.
// RULE7: control register resets to all zeros.
// RULE8: control register is eight bits at special function address 0x88.
// RULE9: external one event sets bit 3; servicing that interrupt clears it.
// RULE10: bit 2 picks level or falling edge for external interrupt one.
// RULE11: bit 4 starts timer zero when one, stops it when zero.
// RULE12: trigger select zero means low level, one means falling edge.
// --------------------------------------------------------------------------
`timescale 1ns/1ns
module tec_control_regs (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_timer_zero_overflow,
  input  wire logic       i_timer_one_overflow,
  input  wire logic       i_ext_zero_pin_n,
  input  wire logic       i_ext_one_pin_n,
  input  wire logic       i_vector_timer_zero,
  input  wire logic       i_vector_timer_one,
  input  wire logic       i_vector_ext_zero,
  input  wire logic       i_vector_ext_one,
  output logic            o_timer_zero_run,
  output logic            o_timer_one_run,
  output logic            o_timer_zero_overflow_flag,
  output logic            o_timer_one_overflow_flag,
  output logic            o_ext_zero_irq_flag,
  output logic            o_ext_one_irq_flag,
  output logic            o_smartcard_irq_enable
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic       timer_one_overflow_flag_q;
  logic       timer_one_run_q;
  logic       timer_zero_overflow_flag_q;
  logic       timer_zero_run_q;
  logic       ext_one_irq_flag_q;
  logic       ext_one_trigger_select_q;
  logic       ext_zero_irq_flag_q;
  logic       ext_zero_trigger_select_q;
  logic       smartcard_irq_enable_q;
  logic [7:0] rdata_q;
  logic [7:0] control_value;
  logic       wr_control;
  logic       wr_enable_second;

  tec_extint_if ext_zero_if ();
  tec_extint_if ext_one_if ();

  // Address decode of the two registers
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  assign wr_control       = i_sfr_wr & addr_hit(i_sfr_addr,
                                               tec_pkg::TIMER_EXTINT_CONTROL_ADDR); // see RULE8
  assign wr_enable_second = i_sfr_wr & addr_hit(i_sfr_addr,
                                               tec_pkg::INTERRUPT_ENABLE_SECOND_ADDR);

  // --------------------------------------------------------------------
  // Pin detectors
  // --------------------------------------------------------------------
  assign ext_zero_if.trigger_select = ext_zero_trigger_select_q;
  assign ext_one_if.trigger_select  = ext_one_trigger_select_q;

  tec_extint_detect u_ext_zero (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pin_n (i_ext_zero_pin_n),
    .port_if (ext_zero_if.det)
  );

  tec_extint_detect u_ext_one (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pin_n (i_ext_one_pin_n),
    .port_if (ext_one_if.det)
  );

  // --------------------------------------------------------------------
  // Timer one overflow flag: set beats clear
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      timer_one_overflow_flag_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                   [tec_pkg::TIMER_ONE_OVERFLOW_BIT]; // see RULE7
    end else if (i_timer_one_overflow) begin
      timer_one_overflow_flag_q <= 1'b1; // see RULE2
    end else if (i_vector_timer_one) begin
      timer_one_overflow_flag_q <= 1'b0; // see RULE2
    end else if (wr_control) begin
      timer_one_overflow_flag_q <= i_sfr_wdata[tec_pkg::TIMER_ONE_OVERFLOW_BIT];
    end
  end

  // Timer zero overflow flag: set beats clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      timer_zero_overflow_flag_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                    [tec_pkg::TIMER_ZERO_OVERFLOW_BIT]; // see RULE7
    end else if (i_timer_zero_overflow) begin
      timer_zero_overflow_flag_q <= 1'b1; // see RULE4
    end else if (i_vector_timer_zero) begin
      timer_zero_overflow_flag_q <= 1'b0; // see RULE4
    end else if (wr_control) begin
      timer_zero_overflow_flag_q <= i_sfr_wdata[tec_pkg::TIMER_ZERO_OVERFLOW_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Run controls and trigger selects, software written
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      timer_one_run_q           <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                   [tec_pkg::TIMER_ONE_RUN_BIT]; // see RULE7
      timer_zero_run_q          <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                   [tec_pkg::TIMER_ZERO_RUN_BIT];
      ext_one_trigger_select_q  <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                   [tec_pkg::EXT_ONE_TRIGGER_BIT];
      ext_zero_trigger_select_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                                   [tec_pkg::EXT_ZERO_TRIGGER_BIT];
    end else if (wr_control) begin
      timer_one_run_q           <= i_sfr_wdata[tec_pkg::TIMER_ONE_RUN_BIT]; // see RULE3
      timer_zero_run_q          <= i_sfr_wdata[tec_pkg::TIMER_ZERO_RUN_BIT]; // see RULE11
      ext_one_trigger_select_q  <= i_sfr_wdata[tec_pkg::EXT_ONE_TRIGGER_BIT]; // see RULE10
      ext_zero_trigger_select_q <= i_sfr_wdata[tec_pkg::EXT_ZERO_TRIGGER_BIT]; // see RULE12
    end
  end

  // --------------------------------------------------------------------
  // External interrupt zero flag
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ext_zero_irq_flag_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                             [tec_pkg::EXT_ZERO_FLAG_BIT]; // see RULE7
    end else if (ext_zero_if.detect) begin
      ext_zero_irq_flag_q <= 1'b1; // see RULE5
    end else if (i_vector_ext_zero &&
                 ext_zero_trigger_select_q == tec_pkg::TRIGGER_FALLING_EDGE) begin
      ext_zero_irq_flag_q <= 1'b0; // see RULE6
    end else if (wr_control) begin
      ext_zero_irq_flag_q <= i_sfr_wdata[tec_pkg::EXT_ZERO_FLAG_BIT];
    end
  end

  // External interrupt one flag
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ext_one_irq_flag_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET
                            [tec_pkg::EXT_ONE_FLAG_BIT]; // see RULE7
    end else if (ext_one_if.detect) begin
      ext_one_irq_flag_q <= 1'b1; // see RULE9
    end else if (i_vector_ext_one) begin
      ext_one_irq_flag_q <= 1'b0; // see RULE9
    end else if (wr_control) begin
      ext_one_irq_flag_q <= i_sfr_wdata[tec_pkg::EXT_ONE_FLAG_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Second interrupt enable register, only the smartcard bit is kept
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      smartcard_irq_enable_q <= tec_pkg::SMARTCARD_IRQ_ENABLE_RESET; // see RULE1
    end else if (wr_enable_second) begin
      smartcard_irq_enable_q <= i_sfr_wdata[tec_pkg::SMARTCARD_IRQ_ENABLE_BIT]; // see RULE1
    end
  end

  // --------------------------------------------------------------------
  // Read path, registered, unmapped reads return zero
  // --------------------------------------------------------------------
  always_comb begin
    control_value = 8'h00;
    control_value[tec_pkg::TIMER_ONE_OVERFLOW_BIT]  = timer_one_overflow_flag_q;
    control_value[tec_pkg::TIMER_ONE_RUN_BIT]       = timer_one_run_q;
    control_value[tec_pkg::TIMER_ZERO_OVERFLOW_BIT] = timer_zero_overflow_flag_q;
    control_value[tec_pkg::TIMER_ZERO_RUN_BIT]      = timer_zero_run_q;
    control_value[tec_pkg::EXT_ONE_FLAG_BIT]        = ext_one_irq_flag_q;
    control_value[tec_pkg::EXT_ONE_TRIGGER_BIT]     = ext_one_trigger_select_q;
    control_value[tec_pkg::EXT_ZERO_FLAG_BIT]       = ext_zero_irq_flag_q;
    control_value[tec_pkg::EXT_ZERO_TRIGGER_BIT]    = ext_zero_trigger_select_q;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= tec_pkg::READ_IDLE_VALUE;
    end else if (i_sfr_rd) begin
      if (addr_hit(i_sfr_addr, tec_pkg::TIMER_EXTINT_CONTROL_ADDR)) begin
        rdata_q <= control_value; // see RULE8
      end else if (addr_hit(i_sfr_addr, tec_pkg::INTERRUPT_ENABLE_SECOND_ADDR)) begin
        rdata_q <= {4'h0, smartcard_irq_enable_q, 3'h0}; // see RULE1
      end else begin
        rdata_q <= tec_pkg::READ_IDLE_VALUE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_sfr_rdata                = rdata_q;
  assign o_timer_zero_run           = timer_zero_run_q;
  assign o_timer_one_run            = timer_one_run_q;
  assign o_timer_zero_overflow_flag = timer_zero_overflow_flag_q;
  assign o_timer_one_overflow_flag  = timer_one_overflow_flag_q;
  assign o_ext_zero_irq_flag        = ext_zero_irq_flag_q;
  assign o_ext_one_irq_flag         = ext_one_irq_flag_q;
  assign o_smartcard_irq_enable     = smartcard_irq_enable_q;

endmodule : tec_control_regs

//--- dv/tec_control_regs_assertions.sv
// Checker: concurrent assertions on the control register ports
`timescale 1ns/1ns
module tec_checker (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_timer_zero_overflow,
  input wire logic       i_timer_one_overflow,
  input wire logic       i_ext_zero_pin_n,
  input wire logic       i_ext_one_pin_n,
  input wire logic       i_vector_timer_zero,
  input wire logic       i_vector_timer_one,
  input wire logic       i_vector_ext_zero,
  input wire logic       i_vector_ext_one,
  input wire logic       o_timer_zero_run,
  input wire logic       o_timer_one_run,
  input wire logic       o_timer_zero_overflow_flag,
  input wire logic       o_timer_one_overflow_flag,
  input wire logic       o_ext_zero_irq_flag,
  input wire logic       o_ext_one_irq_flag,
  input wire logic       o_smartcard_irq_enable
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------
  // Shadow of the ext zero trigger select
  // --------------------------------------------------------------------
  logic wr_ctl;
  logic wr_sec;
  logic trig0_q;
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == tec_pkg::TIMER_EXTINT_CONTROL_ADDR);
  assign wr_sec = i_sfr_wr && (i_sfr_addr == tec_pkg::INTERRUPT_ENABLE_SECOND_ADDR);
  // Follows writes to the control byte
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      trig0_q <= tec_pkg::TIMER_EXTINT_CONTROL_RESET[tec_pkg::EXT_ZERO_TRIGGER_BIT];
    end else if (wr_ctl) begin
      trig0_q <= i_sfr_wdata[tec_pkg::EXT_ZERO_TRIGGER_BIT];
    end
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  a_run_zero_write: assert property (
    wr_ctl |=> o_timer_zero_run == $past(i_sfr_wdata[tec_pkg::TIMER_ZERO_RUN_BIT]))
    else $error("timer zero run wrong");
  a_run_one_write: assert property (
    wr_ctl |=> o_timer_one_run == $past(i_sfr_wdata[tec_pkg::TIMER_ONE_RUN_BIT]))
    else $error("timer one run wrong");
  a_sc_enable_write: assert property (
    wr_sec |=> o_smartcard_irq_enable == $past(i_sfr_wdata[tec_pkg::SMARTCARD_IRQ_ENABLE_BIT]))
    else $error("smartcard enable wrong");
  a_ovf_one_set: assert property (
    i_timer_one_overflow |=> o_timer_one_overflow_flag)
    else $error("timer one flag not set");
  a_ovf_zero_set: assert property (
    i_timer_zero_overflow |=> o_timer_zero_overflow_flag)
    else $error("timer zero flag not set");
  a_ovf_one_clear: assert property (
    i_vector_timer_one && !i_timer_one_overflow |=> !o_timer_one_overflow_flag)
    else $error("timer one flag not cleared");
  a_ovf_zero_clear: assert property (
    i_vector_timer_zero && !i_timer_zero_overflow |=> !o_timer_zero_overflow_flag)
    else $error("timer zero flag not cleared");
  a_ext_zero_level: assert property (
    (!trig0_q && !i_ext_zero_pin_n)[*4] |=> o_ext_zero_irq_flag)
    else $error("ext zero level flag not set");
  a_ext_zero_hold: assert property (
    !trig0_q && o_ext_zero_irq_flag && i_vector_ext_zero && !wr_ctl |=> o_ext_zero_irq_flag)
    else $error("ext zero level flag cleared");
  a_ext_zero_clear: assert property (
    i_ext_zero_pin_n[*5] ##0 (trig0_q && i_vector_ext_zero) |=> !o_ext_zero_irq_flag)
    else $error("ext zero edge flag not cleared");
  a_ext_one_clear: assert property (
    i_ext_one_pin_n[*5] ##0 i_vector_ext_one |=> !o_ext_one_irq_flag)
    else $error("ext one flag not cleared");
  a_read_sc_byte: assert property (
    i_sfr_rd && i_sfr_addr == tec_pkg::INTERRUPT_ENABLE_SECOND_ADDR
    |=> o_sfr_rdata == {4'h0, $past(o_smartcard_irq_enable), 3'h0})
    else $error("enable read wrong");
endmodule : tec_checker

bind tec_control_regs tec_checker u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
  .i_timer_zero_overflow(i_timer_zero_overflow), .i_timer_one_overflow(i_timer_one_overflow),
  .i_ext_zero_pin_n(i_ext_zero_pin_n), .i_ext_one_pin_n(i_ext_one_pin_n),
  .i_vector_timer_zero(i_vector_timer_zero), .i_vector_timer_one(i_vector_timer_one),
  .i_vector_ext_zero(i_vector_ext_zero), .i_vector_ext_one(i_vector_ext_one),
  .o_timer_zero_run(o_timer_zero_run), .o_timer_one_run(o_timer_one_run),
  .o_timer_zero_overflow_flag(o_timer_zero_overflow_flag),
  .o_timer_one_overflow_flag(o_timer_one_overflow_flag),
  .o_ext_zero_irq_flag(o_ext_zero_irq_flag), .o_ext_one_irq_flag(o_ext_one_irq_flag),
  .o_smartcard_irq_enable(o_smartcard_irq_enable));

//--- dv/tb_top.sv
// Testbench: register accesses and event pulses on the control registers
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] SEC = tec_pkg::INTERRUPT_ENABLE_SECOND_ADDR;
  logic       i_mclk      = 1'b0;
  logic       i_rst       = 1'b1;
  logic [7:0] addr        = 8'h00;
  logic       wr          = 1'b0;
  logic [7:0] wdata       = 8'h00;
  logic       rd          = 1'b0;
  logic [5:0] ev          = 6'h00;
  logic [1:0] pin_n       = 2'h3;
  logic [7:0] rdata;
  logic [6:0] outs;
  int         miscompares = 0;
  int         comparisons = 0;
  // Clock at 100 MHz
  always #5 i_mclk = ~i_mclk;
  tec_control_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .i_timer_zero_overflow(ev[0]), .i_timer_one_overflow(ev[1]),
    .i_ext_zero_pin_n(pin_n[0]), .i_ext_one_pin_n(pin_n[1]),
    .i_vector_timer_zero(ev[2]), .i_vector_timer_one(ev[3]),
    .i_vector_ext_zero(ev[4]), .i_vector_ext_one(ev[5]),
    .o_timer_zero_run(outs[0]), .o_timer_one_run(outs[1]),
    .o_timer_zero_overflow_flag(outs[2]), .o_timer_one_overflow_flag(outs[3]),
    .o_ext_zero_irq_flag(outs[4]), .o_ext_one_irq_flag(outs[5]),
    .o_smartcard_irq_enable(outs[6]));
  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge i_mclk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_mclk);
    addr = a;
    rd = 1'b1;
    @(negedge i_mclk);
    rd = 1'b0;
    chk("read data", exp, rdata);
  endtask : rd_chk
  task automatic pulse(input int k);
    @(negedge i_mclk);
    ev[k] = 1'b1;
    @(negedge i_mclk);
    ev = 6'h00;
  endtask : pulse
  task automatic out_chk(input logic [6:0] exp);
    chk("outputs", {1'b0, exp}, {1'b0, outs});
  endtask : out_chk
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : idle
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    idle(20);
    i_rst = 1'b0;
    rd_chk(8'h88, 8'h00);
    rd_chk(SEC, 8'h00);
    wr_reg(8'h88, 8'h50);
    out_chk(7'h03);
    rd_chk(8'h88, 8'h50);
    wr_reg(8'h88, 8'h40);
    out_chk(7'h02);
    wr_reg(SEC, 8'hFF);
    out_chk(7'h42);
    rd_chk(SEC, 8'h08);
    wr_reg(SEC, 8'hF7);
    wr_reg(8'h89, 8'hFF);
    rd_chk(8'h89, 8'h00);
    out_chk(7'h02);
    wr_reg(8'h88, 8'h00);
    pulse(1);
    out_chk(7'h08);
    rd_chk(8'h88, 8'h80);
    pulse(3);
    out_chk(7'h00);
    pulse(0);
    out_chk(7'h04);
    pulse(2);
    out_chk(7'h00);
    // Overflow and vectoring in one cycle: the set wins
    @(negedge i_mclk);
    ev = 6'h0A;
    @(negedge i_mclk);
    ev = 6'h00;
    out_chk(7'h08);
    pulse(3);
    out_chk(7'h00);
    // Edge mode on both external inputs
    wr_reg(8'h88, 8'h05);
    pin_n = 2'h2;
    idle(5);
    out_chk(7'h10);
    rd_chk(8'h88, 8'h07);
    pin_n = 2'h3;
    idle(5);
    pulse(4);
    out_chk(7'h00);
    // Edge mode: a pin held low sets the flag once only
    pin_n = 2'h2;
    idle(5);
    pulse(4);
    idle(3);
    out_chk(7'h00);
    pin_n = 2'h1;
    idle(5);
    out_chk(7'h20);
    pin_n = 2'h3;
    idle(5);
    pulse(5);
    out_chk(7'h00);
    // Level mode: flag stays through servicing
    wr_reg(8'h88, 8'h00);
    pin_n = 2'h0;
    idle(5);
    out_chk(7'h30);
    pulse(4);
    out_chk(7'h30);
    pin_n = 2'h3;
    idle(5);
    wr_reg(8'h88, 8'h00);
    out_chk(7'h00);
    // Reset in mid-run
    wr_reg(8'h88, 8'h50);
    wr_reg(SEC, 8'h08);
    i_rst = 1'b1;
    idle(3);
    i_rst = 1'b0;
    out_chk(7'h00);
    rd_chk(8'h88, 8'h00);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge i_mclk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
